// ### core/bcc_pkg.sv
// shared constants and types for the block check character engine
package bcc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    localparam logic [7:0] OFS_CHARS = 8'h0C;
    localparam logic [7:0] OFS_BCD_IN = 8'h10;
    localparam logic [7:0] OFS_BCD_OUT = 8'h14;

    localparam int unsigned CTRL_CLR_BIT = 8;
    localparam int unsigned STAT_DONE_BIT = 0;
    localparam int unsigned STAT_MISM_BIT = 1;
    localparam int unsigned STAT_BUSY_BIT = 2;
    localparam int unsigned STAT_HALF_BIT = 3;
    localparam int unsigned RESULT_CNT_LSB = 16;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [2:0] CRC_LAST_STEP = 3'h7;
    localparam logic [2:0] LRC_CHARS = 3'h2;
    localparam logic [2:0] CRC_CHARS = 3'h2;
    localparam logic [2:0] MAX_ASCII_DIGITS = 3'h4;
    localparam logic [2:0] MAX_BIN_DIGITS = 3'h2;
    localparam int unsigned FIFO_DEPTH = 32;

    localparam logic [7:0] ASC_ZERO = 8'h30;
    localparam logic [7:0] ASC_UPPER = 8'h37;
    localparam logic [7:0] ASC_LOWER = 8'h57;

    typedef enum logic [1:0] {MODE_ADD, MODE_LRC, MODE_CRC} mode_e;

    typedef struct packed {
        logic rx;
        logic [2:0] digits;
        logic ascii;
        mode_e mode;
    } ctrl_s;

    localparam ctrl_s CTRL_RST = '{rx: 1'b0, digits: 3'h2, ascii: 1'b0, mode: MODE_ADD};

    typedef struct packed {
        logic last;
        logic is_chk;
        logic [7:0] data;
    } item_s;

    localparam int unsigned ITEM_W = $bits(item_s);

    typedef struct packed {
        logic [15:0] value;
        logic [2:0] cnt;
        logic [3:0][7:0] ch;
    } chk_s;

    typedef struct packed {
        logic [2:0] digits;
        logic [15:0] value;
    } bcd_s;

    localparam bcd_s BCD_RST = '{digits: 3'h4, value: 16'h0000};
endpackage

// ### core/byte_fifo.sv
// first-in first-out buffer of flip-flops with valid and ready on both sides
module byte_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    // depth must be a power of two: pointers wrap naturally
    localparam int unsigned PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_reg;
    logic [PTR_W-1:0] rd_reg;
    logic [PTR_W:0] cnt_reg;
    logic [PTR_W:0] cnt_next;
    logic push;
    logic pop;

    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem_reg[rd_reg];

    always_comb begin
        cnt_next = cnt_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_reg[wr_reg] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
            o_in_ready <= 1'b0;
            o_out_valid <= 1'b0;
        end else begin
            wr_reg <= wr_reg + PTR_W'(push);
            rd_reg <= rd_reg + PTR_W'(pop);
            cnt_reg <= cnt_next;
            // flags from the next count keep them honest without a combinational path
            o_in_ready <= (cnt_next != FULL_CNT);
            o_out_valid <= (cnt_next != '0);
        end
    end
endmodule

// ### core/block_check_char_gen.sv
// block check character engine: additive, lrc and crc-16 over a byte stream, axi4-lite registers
// Notes on behaviour
// - any of the three check formulas can be chosen for outgoing and for incoming frames alike.
// - additive mode sums every covered byte before the check field and takes the two's complement.
// - the additive result goes out raw or as ascii hex, using the set number of low-order digits.
// - lrc mode first folds each pair of ascii hex characters into one binary byte.
// - lrc mode sums the folded bytes and takes the two's complement of the sum.
// - lrc mode keeps only the low byte and sends it as two ascii hex characters, high nibble first.
// - crc mode starts at all ones and xors the first byte into the low bits.
// - each crc step shifts right one bit and xors the reflected polynomial when a one falls out.
// - exactly eight crc steps are made for each byte before the next is taken.
// - after the eight steps the next byte is xored in, up to the last byte before the check field.
// - the crc goes out low byte first, then high byte.
// - bcd conversion turns each nibble into one ascii digit and sends only the set digit count.
module block_check_char_gen (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_in_valid,
    input wire bcc_pkg::item_s i_in_item,
    output logic o_in_ready,
    output bcc_pkg::chk_s o_chk,
    output logic o_done,
    output logic o_mismatch
);
    typedef enum logic {ST_IDLE, ST_SHIFT} state_e;

    bcc_pkg::ctrl_s ctrl_reg;
    bcc_pkg::bcd_s bcd_reg;
    logic [31:0] bcd_out_reg;
    state_e state_reg;
    logic [2:0] step_reg;
    logic [15:0] sum_reg;
    logic [15:0] crc_reg;
    logic half_reg;
    logic [3:0] hi_reg;
    logic [2:0] chk_idx_reg;
    logic aw_got_reg;
    logic w_got_reg;
    logic [7:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic clr;
    logic fifo_vld;
    bcc_pkg::item_s item;
    logic pop;
    logic data_pop;
    logic chk_pop;
    logic bad_char;
    logic bad_count;
    bcc_pkg::chk_s chk_now;
    logic [31:0] rd_word;
    logic rd_hit;
    logic last_pend_reg;
    logic crc_tail;
    logic shift_end;

    function automatic logic [7:0] hex2asc(input logic [3:0] n);
        return (n < 4'hA) ? bcc_pkg::ASC_ZERO + {4'h0, n} : bcc_pkg::ASC_UPPER + {4'h0, n};
    endfunction

    function automatic logic [3:0] asc2hex(input logic [7:0] c);
        logic [7:0] v;
        if (c >= 8'h61) begin
            v = c - bcc_pkg::ASC_LOWER;
        end else if (c >= 8'h41) begin
            v = c - bcc_pkg::ASC_UPPER;
        end else begin
            v = c - bcc_pkg::ASC_ZERO;
        end
        return v[3:0];
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // check characters from the running accumulators

    always_comb begin
        logic [15:0] cmp;
        logic [2:0] n;
        logic [2:0] sh;
        cmp = ~sum_reg + 16'h0001;
        n = (ctrl_reg.digits == 3'h0) ? 3'h1 : ctrl_reg.digits;
        sh = 3'h0;
        chk_now = '0;
        unique case (ctrl_reg.mode)
            bcc_pkg::MODE_ADD: begin
                chk_now.value = cmp;
                if (ctrl_reg.ascii) begin
                    n = (n > bcc_pkg::MAX_ASCII_DIGITS) ? bcc_pkg::MAX_ASCII_DIGITS : n;
                    for (int i = 0; i < 4; i++) begin
                        sh = n - 3'(i) - 3'h1;
                        if (3'(i) < n) begin
                            chk_now.ch[i] = hex2asc(4'(cmp >> {sh, 2'b00}));
                        end
                    end
                end else begin
                    n = (n > bcc_pkg::MAX_BIN_DIGITS) ? bcc_pkg::MAX_BIN_DIGITS : n;
                    if (n == 3'h1) begin
                        chk_now.ch[0] = cmp[7:0];
                    end else begin
                        chk_now.ch[0] = cmp[15:8];
                        chk_now.ch[1] = cmp[7:0];
                    end
                end
                chk_now.cnt = n;
            end
            bcc_pkg::MODE_LRC: begin
                chk_now.value = {8'h00, cmp[7:0]};
                chk_now.ch[0] = hex2asc(cmp[7:4]);
                chk_now.ch[1] = hex2asc(cmp[3:0]);
                chk_now.cnt = bcc_pkg::LRC_CHARS;
            end
            bcc_pkg::MODE_CRC: begin
                chk_now.value = crc_reg;
                chk_now.ch[0] = crc_reg[7:0];
                chk_now.ch[1] = crc_reg[15:8];
                chk_now.cnt = bcc_pkg::CRC_CHARS;
            end
            default: begin
                chk_now.cnt = 3'h0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // byte stream: fifo, then the engine drains it one item per step

    byte_fifo #(.WIDTH(bcc_pkg::ITEM_W), .DEPTH(bcc_pkg::FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_in_valid(i_in_valid),
        .i_in_data(i_in_item),
        .o_in_ready(o_in_ready),
        .o_out_valid(fifo_vld),
        .o_out_data(item),
        .i_out_ready(state_reg == ST_IDLE)
    );

    // crc shifting stalls the fifo, so back-pressure reaches the frame logic
    assign pop = fifo_vld && (state_reg == ST_IDLE);
    assign data_pop = pop && !item.is_chk;
    assign chk_pop = pop && item.is_chk && ctrl_reg.rx;
    assign bad_char = chk_pop && ((chk_idx_reg >= chk_now.cnt) || (item.data != chk_now.ch[chk_idx_reg[1:0]]));
    assign bad_count = pop && item.last && ctrl_reg.rx && ((chk_idx_reg + 3'(chk_pop)) != chk_now.cnt);
    assign crc_tail = data_pop && item.last && ctrl_reg.mode == bcc_pkg::MODE_CRC;
    assign shift_end = state_reg == ST_SHIFT && step_reg == bcc_pkg::CRC_LAST_STEP;

    always_ff @(posedge i_clk) begin
        if (i_srst || clr) begin
            state_reg <= ST_IDLE;
            step_reg <= 3'h0;
        end else if (data_pop && ctrl_reg.mode == bcc_pkg::MODE_CRC) begin
            state_reg <= ST_SHIFT;
            step_reg <= 3'h0;
        end else if (state_reg == ST_SHIFT) begin
            step_reg <= step_reg + 3'h1;
            if (step_reg == bcc_pkg::CRC_LAST_STEP) begin
                state_reg <= ST_IDLE;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst || clr) begin
            crc_reg <= bcc_pkg::CRC_INIT;
        end else if (data_pop && ctrl_reg.mode == bcc_pkg::MODE_CRC) begin
            crc_reg <= crc_reg ^ {8'h00, item.data};
        end else if (state_reg == ST_SHIFT) begin
            crc_reg <= crc_reg[0] ? ((crc_reg >> 1) ^ bcc_pkg::CRC_POLY) : (crc_reg >> 1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst || clr) begin
            sum_reg <= 16'h0000;
            half_reg <= 1'b0;
            hi_reg <= 4'h0;
        end else if (data_pop && ctrl_reg.mode == bcc_pkg::MODE_ADD) begin
            sum_reg <= sum_reg + {8'h00, item.data};
        end else if (data_pop && ctrl_reg.mode == bcc_pkg::MODE_LRC) begin
            // an odd range leaves a dangling high nibble that is never summed
            half_reg <= !half_reg;
            if (half_reg) begin
                sum_reg <= sum_reg + {8'h00, hi_reg, asc2hex(item.data)};
            end else begin
                hi_reg <= asc2hex(item.data);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst || clr) begin
            chk_idx_reg <= 3'h0;
        end else if (chk_pop && chk_idx_reg != 3'h7) begin
            chk_idx_reg <= chk_idx_reg + 3'h1;
        end
    end

    // a closing crc byte holds done back until its eight steps are over, so the result read is final
    always_ff @(posedge i_clk) begin
        if (i_srst || clr) begin
            last_pend_reg <= 1'b0;
        end else if (crc_tail) begin
            last_pend_reg <= 1'b1;
        end else if (shift_end) begin
            last_pend_reg <= 1'b0;
        end
    end

    // a set in the same cycle as a software clear wins
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_done <= 1'b0;
            o_mismatch <= 1'b0;
        end else begin
            if ((pop && item.last && !crc_tail) || (last_pend_reg && shift_end)) begin
                o_done <= 1'b1;
            end else if (clr) begin
                o_done <= 1'b0;
            end
            if (bad_char || bad_count) begin
                o_mismatch <= 1'b1;
            end else if (clr) begin
                o_mismatch <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_chk <= '0;
        end else begin
            o_chk <= chk_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bcd to ascii field conversion

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            bcd_out_reg <= 32'h0000_0000;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (3'(i) < bcd_reg.digits) begin
                    bcd_out_reg[8*i +: 8] <= bcc_pkg::ASC_ZERO +
                        {4'h0, 4'(bcd_reg.value >> {bcd_reg.digits - 3'(i) - 3'h1, 2'b00})};
                end else begin
                    bcd_out_reg[8*i +: 8] <= 8'h00;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave: address and data taken in either order, one write and one read at a time

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= bcc_pkg::RESP_OKAY;
            waddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            o_awready <= i_awvalid && !o_awready && !aw_got_reg && !o_bvalid;
            o_wready <= i_wvalid && !o_wready && !w_got_reg && !o_bvalid;
            if (i_awvalid && o_awready) begin
                aw_got_reg <= 1'b1;
                waddr_reg <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_got_reg <= 1'b1;
                wdata_reg <= i_wdata;
                wstrb_reg <= i_wstrb;
            end
            if (aw_got_reg && w_got_reg && !o_bvalid) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= (waddr_reg[7:2] <= bcc_pkg::OFS_BCD_OUT[7:2]) ? bcc_pkg::RESP_OKAY : bcc_pkg::RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    assign clr = aw_got_reg && w_got_reg && !o_bvalid && waddr_reg[7:2] == bcc_pkg::OFS_CTRL[7:2] &&
        wstrb_reg[bcc_pkg::CTRL_CLR_BIT / 8] && wdata_reg[bcc_pkg::CTRL_CLR_BIT];

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctrl_reg <= bcc_pkg::CTRL_RST;
            bcd_reg <= bcc_pkg::BCD_RST;
        end else if (aw_got_reg && w_got_reg && !o_bvalid) begin
            if (waddr_reg[7:2] == bcc_pkg::OFS_CTRL[7:2]) begin
                ctrl_reg <= $bits(bcc_pkg::ctrl_s)'(merge(32'(ctrl_reg), wdata_reg, wstrb_reg));
            end
            if (waddr_reg[7:2] == bcc_pkg::OFS_BCD_IN[7:2]) begin
                bcd_reg <= $bits(bcc_pkg::bcd_s)'(merge(32'(bcd_reg), wdata_reg, wstrb_reg));
            end
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (i_araddr[7:2])
            bcc_pkg::OFS_CTRL[7:2]: rd_word = 32'(ctrl_reg);
            bcc_pkg::OFS_STATUS[7:2]: begin
                rd_word[bcc_pkg::STAT_DONE_BIT] = o_done;
                rd_word[bcc_pkg::STAT_MISM_BIT] = o_mismatch;
                rd_word[bcc_pkg::STAT_BUSY_BIT] = fifo_vld || (state_reg != ST_IDLE);
                rd_word[bcc_pkg::STAT_HALF_BIT] = half_reg;
            end
            bcc_pkg::OFS_RESULT[7:2]: rd_word = {13'h0000, o_chk.cnt, o_chk.value};
            bcc_pkg::OFS_CHARS[7:2]: rd_word = o_chk.ch;
            bcc_pkg::OFS_BCD_IN[7:2]: rd_word = 32'(bcd_reg);
            bcc_pkg::OFS_BCD_OUT[7:2]: rd_word = bcd_out_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= bcc_pkg::RESP_OKAY;
        end else begin
            o_arready <= i_arvalid && !o_arready && !o_rvalid;
            if (i_arvalid && o_arready) begin
                o_rvalid <= 1'b1;
                o_rdata <= rd_word;
                o_rresp <= rd_hit ? bcc_pkg::RESP_OKAY : bcc_pkg::RESP_SLVERR;
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    AST_CRC_EIGHT_STEPS: assert property (
        data_pop && ctrl_reg.mode == bcc_pkg::MODE_CRC && !clr |=> (state_reg == ST_SHIFT)[*8] ##1 state_reg == ST_IDLE)
        else $error("crc did not take exactly eight steps");
    AST_CRC_STEP: assert property (
        state_reg == ST_SHIFT && !clr |=> crc_reg == ($past(crc_reg[0]) ?
            (($past(crc_reg) >> 1) ^ bcc_pkg::CRC_POLY) : ($past(crc_reg) >> 1)))
        else $error("crc step wrong");
    AST_CRC_START: assert property (clr |=> crc_reg == bcc_pkg::CRC_INIT)
        else $error("crc not preset to all ones");
    AST_CRC_NEXT_BYTE: assert property (
        data_pop && ctrl_reg.mode == bcc_pkg::MODE_CRC && !clr |=> crc_reg == ($past(crc_reg) ^ {8'h00, $past(item.data)}))
        else $error("byte not xored into crc");
    AST_ADD_SUM: assert property (
        data_pop && ctrl_reg.mode == bcc_pkg::MODE_ADD && !clr ##1 1'b1 ##1 1'b1 |->
            o_chk.value == 16'(~$past(sum_reg) + 16'h0001))
        else $error("additive check not two's complement of sum");
    AST_LRC_PAIR: assert property (
        data_pop && ctrl_reg.mode == bcc_pkg::MODE_LRC && half_reg && !clr |=>
            sum_reg == 16'($past(sum_reg) + {8'h00, $past(hi_reg), asc2hex($past(item.data))}))
        else $error("lrc pair not folded into sum");
    AST_LRC_TWO_CHARS: assert property (ctrl_reg.mode == bcc_pkg::MODE_LRC && $stable(ctrl_reg) |=>
        o_chk.cnt == 3'h2 && o_chk.ch[0] == hex2asc(o_chk.value[7:4]))
        else $error("lrc not two ascii characters");
    AST_CRC_SWAP: assert property (ctrl_reg.mode == bcc_pkg::MODE_CRC && $stable(ctrl_reg) |=>
        o_chk.ch[0] == $past(crc_reg[7:0]) && o_chk.ch[1] == $past(crc_reg[15:8]))
        else $error("crc bytes not swapped");
    AST_RX_MISMATCH: assert property (bad_char |=> o_mismatch)
        else $error("mismatch not flagged");
    AST_BCD_DIGIT: assert property (bcd_reg.digits == 3'h2 && $stable(bcd_reg) |=>
        bcd_out_reg[15:8] == bcc_pkg::ASC_ZERO + {4'h0, $past(bcd_reg.value[3:0])} && bcd_out_reg[31:16] == 16'h0000)
        else $error("bcd digits wrong");

    COV_CRC_FRAME: cover property (ctrl_reg.mode == bcc_pkg::MODE_CRC && pop && item.last);
    COV_LRC_FRAME: cover property (ctrl_reg.mode == bcc_pkg::MODE_LRC && pop && item.last);
    COV_RX_MISMATCH: cover property (ctrl_reg.rx && $rose(o_mismatch));
    COV_FIFO_FULL: cover property (!o_in_ready && i_in_valid);
endmodule

// ### tb/frame_source.sv
// frame byte source standing in for the serial frame logic
module frame_source (
    input wire logic i_clk,
    input wire logic i_ready,
    input wire logic i_pause,
    output logic o_valid,
    output bcc_pkg::item_s o_item
);
    timeunit 1ns;
    timeprecision 1ns;
    bcc_pkg::item_s q[$];
    int stalls = 0;
    initial begin
        o_valid = 1'h0;
        o_item = '0;
    end
    // an offer is never withdrawn; idle item lines show the inverse so stale data cannot pass
    always @(posedge i_clk) begin
        if (o_valid && i_ready) begin
            void'(q.pop_front());
        end
        if (o_valid && !i_ready) begin
            stalls++;
        end else if (q.size() != 0 && !i_pause) begin
            o_valid <= 1'h1;
            o_item <= q[0];
        end else begin
            o_valid <= 1'h0;
            o_item <= ~o_item;
        end
    end
endmodule

// ### tb/testbench.sv
// self-checking bench for the block check character engine
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'h0;
    logic i_srst = 1'h1;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, pause = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd, rdata;
    logic [1:0] rsp, bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, in_valid, in_ready, done, mism;
    bcc_pkg::item_s item;
    bcc_pkg::chk_s chk;
    logic [7:0] bq[$];
    logic [7:0] mb[$] = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
    int err_total = 0;
    int checked = 0;
    block_check_char_gen dut (.i_clk(i_clk), .i_srst(i_srst), .i_awvalid(awvalid), .o_awready(awready),
        .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hF),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
        .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
        .i_in_valid(in_valid), .i_in_item(item), .o_in_ready(in_ready), .o_chk(chk), .o_done(done),
        .o_mismatch(mism));
    frame_source src (.i_clk(i_clk), .i_ready(in_ready), .i_pause(pause), .o_valid(in_valid), .o_item(item));
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("counts: %0d compared, %0d mismatched", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // trailing edge keeps the next call from assigning a strobe twice in one step
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge i_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        rsp = bresp;
        bready <= 1'h0;
        @(posedge i_clk);
    endtask
    task automatic axr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge i_clk);
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rd = rdata;
        rsp = rresp;
        rready <= 1'h0;
        @(posedge i_clk);
    endtask
    // clear, stream bq (last nchk bytes are check bytes), wait done, read chars
    task automatic frame(input logic [7:0] ctrl, input int nchk);
        int n;
        n = bq.size();
        axw(bcc_pkg::OFS_CTRL, {23'h0, 1'h1, ctrl});
        for (int i = 0; i < n; i++) begin
            src.q.push_back(bcc_pkg::item_s'{last: i == n - 1, is_chk: i >= n - nchk, data: bq[i]});
        end
        bq.delete();
        for (int i = 0; i < 3000 && done !== 1'h1; i++) @(posedge i_clk);
        if (done !== 1'h1) err_total++;
        axr(bcc_pkg::OFS_CHARS);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_bus;
        axr(8'h40);
        check(32'(rsp), 32'(bcc_pkg::RESP_SLVERR));
        axw(8'h40, 32'h0);
        check(32'(rsp), 32'(bcc_pkg::RESP_SLVERR));
        axw(bcc_pkg::OFS_BCD_IN, 32'h0004_1234);
        axr(bcc_pkg::OFS_BCD_OUT);
        check(32'(rsp), 32'(bcc_pkg::RESP_OKAY));
        check(rd, 32'h3433_3231);
        axw(bcc_pkg::OFS_BCD_IN, 32'h0002_0059);
        axr(bcc_pkg::OFS_BCD_OUT);
        check(rd, 32'h0000_3935);
        $display("bus and bcd test done");
    endtask
    task automatic t_add;
        // 80h+F5h carries out of a byte, so a narrow adder shows up
        bq = '{8'h80, 8'hF5};
        frame(8'h14, 0);
        check(32'(rd[15:0]), 32'h4238);
        bq = '{8'h80, 8'hF5};
        frame(8'h10, 0);
        check(32'(rd[15:0]), 32'h8BFE);
        bq = '{8'h80, 8'hF5};
        frame(8'h24, 0);
        check(rd, 32'h4238_4546);
        bq = '{8'h80, 8'hF5, 8'h38, 8'h42};
        frame(8'h54, 2);
        check(32'(mism), 32'h0);
        bq = '{8'h31, 8'h32, 8'h33, 8'h34}; // even count only
        fork
            frame(8'h11, 0);
            repeat (10) @(posedge i_clk) pause <= ~pause;
        join
        pause <= 1'h0;
        check(32'(rd[15:0]), 32'h4142);
        $display("additive and lrc test done");
    endtask
    task automatic t_crc;
        bq = mb;
        frame(8'h12, 0);
        check(32'(rd[15:0]), 32'h0A84);
        check(32'(chk.cnt), 32'h2);
        check(32'(chk.value), 32'h0A84);
        bq = mb;
        bq.push_back(8'h84);
        bq.push_back(8'h0A);
        frame(8'h52, 2);
        check(32'(mism), 32'h0);
        bq = mb;
        bq.push_back(8'h85);
        bq.push_back(8'h0A);
        frame(8'h52, 2);
        check(32'(mism), 32'h1);
        $display("crc test done");
    endtask
    // long frame outruns the eight-step engine, so the buffer must refuse
    task automatic t_fill;
        logic [15:0] c;
        logic [7:0] b;
        c = 16'hFFFF;
        for (int i = 0; i < 40; i++) begin
            b = 8'(i * 37);
            bq.push_back(b);
            c = c ^ {8'h00, b};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        frame(8'h12, 0);
        check(32'(rd[15:0]), 32'(c));
        check(32'(src.stalls > 0), 32'h1);
        $display("fill test done");
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        err_total++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge i_clk);
        i_srst <= 1'h0;
        @(posedge i_clk);
        t_bus();
        t_add();
        t_crc();
        t_fill();
        end_of_test();
    end
endmodule
